// *** hw/scs_consts.svh ***
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// Register byte offsets
`define SCS_OFF_REQUEST 8'h00
`define SCS_OFF_CURRENT 8'h04
`define SCS_OFF_CONTROL 8'h08
`define SCS_OFF_READY 8'h0C
`define SCS_OFF_FLAGS 8'h10

// Field positions
`define SCS_SRC_MSB 6
`define SCS_SRC_LSB 4
`define SCS_DIV_MSB 3
`define SCS_DIV_LSB 0
`define SCS_HOLD_BIT 7
`define SCS_SECPWR_BIT 6
`define SCS_MATCH_BIT 4
`define SCS_NSR_BIT 3
`define SCS_FLAG_FAIL_BIT 0
`define SCS_FLAG_DONE_BIT 1
`define SCS_FLAG_SAFE_BIT 2

// Source codes
`define SCS_SRC_EXT 3'h7
`define SCS_SRC_HF 3'h6
`define SCS_SRC_LF 3'h5
`define SCS_SRC_SEC 3'h4
`define SCS_SRC_RSV_HI 3'h3
`define SCS_SRC_EXT_PLL 3'h2
`define SCS_SRC_HF_PLL 3'h1
`define SCS_SRC_RSV_LO 3'h0

// Divider codes
`define SCS_DIV_ONE 4'h0
`define SCS_DIV_HF_RESET 4'h2
`define SCS_DIV_FAILSAFE 4'h2

// Values before the configuration bits are caught
`define SCS_SRC_RESET 3'h6
`define SCS_DIV_RESET 4'h2

// Timing counts
`define SCS_INIT_CYCLES 2'h3
`define SCS_STARTUP_CYCLES 1024

`endif

// *** hw/scs_pkg.sv ***
package scs_pkg;
   typedef enum logic [1:0] {
      MODE_INIT = 2'b00,
      MODE_RUN = 2'b01,
      MODE_SLEEP = 2'b10
   } scs_mode_t;
endpackage

// *** hw/scs_startup_timer.sv ***
`timescale 1ns/1ps
`include "scs_consts.svh"
module scs_startup_timer #(
   parameter int CYCLES = `SCS_STARTUP_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic restart,
   input wire logic bypass,
   output logic running,
   output logic expirePulse
);
   logic [31:0] count;

   // Starts counting out of reset, so the monitor waits after every reset unless bypass is set
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= 32'h0000_0000;
         running <= 1'b1;
         expirePulse <= 1'b0;
      end else if (restart) begin
         count <= 32'h0000_0000;
         running <= !bypass;
         expirePulse <= bypass;
      end else if (running && bypass) begin
         running <= 1'b0;
         expirePulse <= 1'b1;
      end else if (running && count == 32'(CYCLES - 1)) begin
         running <= 1'b0;
         expirePulse <= 1'b1;
      end else begin
         count <= running ? count + 32'h0000_0001 : count;
         expirePulse <= 1'b0;
      end
   end
endmodule // scs_startup_timer

// *** hw/scs_clock_switch.sv ***
// Overview of operation
// - Clear fail-safe on reset, sleep, internal-source request write
// - External switch restarts timer, stays internal meanwhile
// - Fail-safe clears once external switch completes
// - Persisting failure sets fail flag again
// - Monitor armed after timer; timer after reset/wake
// - External clock input mode skips start-up timer
// - Request register: source 6:4, divider 3:0
// - Power-on source request from configuration bits
// - Reserved source write ignored entirely
// - Switch-enable config low makes request read-only
// - Reset divider 0010 for source 110, else 0000
// - Current register shows active source and divider
// - Current fields reset equal to request fields
// - Source code map, 011 and 000 reserved
// - Divider codes 0000-1001 divide 1 to 512
// - Hold bit suspends switch once source ready
// - Bit 6 selects secondary oscillator power mode
// - Match bit set when request equals current
// - New-ready bit: switch pending and source ready
// - Ready status bits per oscillator, bit 1 zero
// - PLL ready needs enable, input ready, lock
// - On switch update current, set match, clear ready
// - Failure forces internal 1 MHz, sets fail flag
// - Sleep suspends an unfinished switch until wake
`timescale 1ns/1ps
`include "scs_consts.svh"
module scs_clock_switch #(
   parameter int STARTUP_CYCLES = `SCS_STARTUP_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [2:0] resetOscConfig,
   input wire logic switchEnableConfig,
   input wire logic externalClockInputMode,
   input wire logic extOscReadyIn,
   input wire logic hfReadyIn,
   input wire logic mfReadyIn,
   input wire logic lfReadyIn,
   input wire logic secReadyIn,
   input wire logic convReadyIn,
   input wire logic pllEnabledIn,
   input wire logic pllLockedIn,
   input wire logic clockFailIn,
   input wire logic sleepEnter,
   input wire logic wakeUp,
   output logic [2:0] sysSource,
   output logic [3:0] sysDivider,
   output logic secPowerHigh,
   output logic monitorActive,
   output logic failSafeActive,
   output logic oscFailFlag,
   output logic switchDoneFlag,
   output logic startupRunning
);
   localparam int SYNC_W = 14;

   logic [SYNC_W-1:0] rawIn;
   logic [SYNC_W-1:0] syncIn;
   logic [2:0] cfgSource;
   logic cfgSwitchEn;
   logic cfgExtClock;
   logic extReady, hfReady, mfReady, lfReady, secReady, convReady;
   logic pllEnabled, pllLocked, clockFail;

   scs_pkg::scs_mode_t mode;
   logic [1:0] initCount;
   logic [2:0] reqSource;
   logic [3:0] reqDivider;
   logic switchHold;
   logic newSourceReady;
   logic extGate;
   logic pllReady;
   logic [7:0] readyStatus;
   logic timerRestart;
   logic timerExpire;
   logic failDetect;
   logic switchNow;
   logic pending;

   logic dpWrite;
   logic [2:0] dpSel;
   logic reqWrite;
   logic reqAccept;
   logic [2:0] wrSource;

   function automatic logic isExternal(input logic [2:0] src);
      isExternal = (src == `SCS_SRC_EXT) || (src == `SCS_SRC_EXT_PLL);
   endfunction

   function automatic logic isReserved(input logic [2:0] src);
      isReserved = (src == `SCS_SRC_RSV_HI) || (src == `SCS_SRC_RSV_LO);
   endfunction

   function automatic logic [3:0] resetDivider(input logic [2:0] src);
      resetDivider = (src == `SCS_SRC_HF) ? `SCS_DIV_HF_RESET : `SCS_DIV_ONE;
   endfunction

   // 0..4 select a register, 7 marks an unmapped address
   function automatic logic [2:0] regSelect(input logic [31:0] addr);
      regSelect = 3'h7;
      if (addr[31:8] == 24'h00_0000) begin
         case (addr[7:0])
            `SCS_OFF_REQUEST: regSelect = 3'h0;
            `SCS_OFF_CURRENT: regSelect = 3'h1;
            `SCS_OFF_CONTROL: regSelect = 3'h2;
            `SCS_OFF_READY: regSelect = 3'h3;
            `SCS_OFF_FLAGS: regSelect = 3'h4;
            default: regSelect = 3'h7;
         endcase
      end
   endfunction

   // Every pin-side level passes two flip-flops first
   assign rawIn = {resetOscConfig, switchEnableConfig, externalClockInputMode, extOscReadyIn,
      hfReadyIn, mfReadyIn, lfReadyIn, secReadyIn, convReadyIn, pllEnabledIn, pllLockedIn,
      clockFailIn};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : gSync
         logic meta;
         logic live;
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               meta <= 1'b0;
               live <= 1'b0;
            end else begin
               meta <= rawIn[gi];
               live <= meta;
            end
         end
         assign syncIn[gi] = live;
      end
   endgenerate

   assign {cfgSource, cfgSwitchEn, cfgExtClock, extReady, hfReady, mfReady, lfReady, secReady,
      convReady, pllEnabled, pllLocked, clockFail} = syncIn;

   // PLL input follows the request while it names a PLL, else the running source
   always_comb begin
      logic [2:0] pllInput;
      logic inputReady;
      pllInput = (reqSource == `SCS_SRC_EXT_PLL || reqSource == `SCS_SRC_HF_PLL) ?
         reqSource : sysSource;
      inputReady = (pllInput == `SCS_SRC_EXT_PLL) ? extReady :
         (pllInput == `SCS_SRC_HF_PLL) ? hfReady : 1'b0;
      pllReady = pllEnabled && pllLocked && inputReady;
   end

   assign readyStatus = {extReady, hfReady, mfReady, lfReady, secReady, convReady,
      1'b0, pllReady};

   function automatic logic sourceReady(input logic [2:0] src, input logic [7:0] rdy);
      case (src)
         `SCS_SRC_EXT: sourceReady = rdy[7];
         `SCS_SRC_HF: sourceReady = rdy[6];
         `SCS_SRC_LF: sourceReady = rdy[4];
         `SCS_SRC_SEC: sourceReady = rdy[3];
         `SCS_SRC_EXT_PLL: sourceReady = rdy[0];
         `SCS_SRC_HF_PLL: sourceReady = rdy[0];
         default: sourceReady = 1'b0;
      endcase
   endfunction

   assign pending = (reqSource != sysSource) || (reqDivider != sysDivider);
   assign wrSource = hwdata[`SCS_SRC_MSB:`SCS_SRC_LSB];
   assign reqWrite = dpWrite && dpSel == 3'h0;
   assign reqAccept = reqWrite && mode == scs_pkg::MODE_RUN && cfgSwitchEn &&
      !isReserved(wrSource);
   assign timerRestart = (reqAccept && isExternal(wrSource)) || wakeUp;
   assign failDetect = monitorActive && clockFail && isExternal(sysSource) && !failSafeActive &&
      mode == scs_pkg::MODE_RUN && !sleepEnter;
   // Switch to an external source also waits for the start-up timer
   assign switchNow = newSourceReady && !switchHold && mode == scs_pkg::MODE_RUN && pending &&
      (!isExternal(reqSource) || extGate) && !failDetect;

   scs_startup_timer #(
      .CYCLES(STARTUP_CYCLES)
   ) uTimer (
      .clk(clk),
      .arst_n(arst_n),
      .restart(timerRestart),
      .bypass(cfgExtClock),
      .running(startupRunning),
      .expirePulse(timerExpire)
   );

   // Init waits for the configuration synchronisers to settle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode <= scs_pkg::MODE_INIT;
         initCount <= 2'h0;
      end else begin
         case (mode)
            scs_pkg::MODE_INIT: begin
               initCount <= initCount + 2'h1;
               if (initCount == `SCS_INIT_CYCLES) begin
                  mode <= scs_pkg::MODE_RUN;
               end
            end
            scs_pkg::MODE_RUN: begin
               if (sleepEnter) begin
                  mode <= scs_pkg::MODE_SLEEP;
               end
            end
            scs_pkg::MODE_SLEEP: begin
               if (wakeUp) begin
                  mode <= scs_pkg::MODE_RUN;
               end
            end
            default: mode <= scs_pkg::MODE_INIT;
         endcase
      end
   end

   // Request fields
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reqSource <= `SCS_SRC_RESET;
         reqDivider <= `SCS_DIV_RESET;
      end else if (mode == scs_pkg::MODE_INIT) begin
         reqSource <= cfgSource;
         reqDivider <= resetDivider(cfgSource);
      end else if (reqAccept) begin
         reqSource <= wrSource;
         reqDivider <= hwdata[`SCS_DIV_MSB:`SCS_DIV_LSB];
      end
   end

   // Current fields; a failure overrides any switch in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sysSource <= `SCS_SRC_RESET;
         sysDivider <= `SCS_DIV_RESET;
      end else if (mode == scs_pkg::MODE_INIT) begin
         sysSource <= cfgSource;
         sysDivider <= resetDivider(cfgSource);
      end else if (failDetect) begin
         sysSource <= `SCS_SRC_HF;
         sysDivider <= `SCS_DIV_FAILSAFE;
      end else if (switchNow) begin
         sysSource <= reqSource;
         sysDivider <= reqDivider;
      end
   end

   // Pending and ready; dropped in sleep so the switch waits until wake
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         newSourceReady <= 1'b0;
      end else begin
         newSourceReady <= pending && !switchNow && mode == scs_pkg::MODE_RUN && !sleepEnter &&
            sourceReady(reqSource, readyStatus);
      end
   end

   // Gate to an external source; a failure shuts it until a new request or a wake restarts the timer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         extGate <= 1'b0;
      end else if (failDetect) begin
         extGate <= 1'b0;
      end else if (timerRestart) begin
         extGate <= cfgExtClock;
      end else if (timerExpire) begin
         extGate <= 1'b1;
      end
   end

   // Monitor is armed after the start-up timer has expired, or at once in external clock input mode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         monitorActive <= 1'b0;
      end else if (timerRestart || mode != scs_pkg::MODE_RUN) begin
         monitorActive <= 1'b0;
      end else if (timerExpire || cfgExtClock) begin
         monitorActive <= 1'b1;
      end
   end

   // A request for external keeps the condition until that switch lands
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         failSafeActive <= 1'b0;
      end else if (failDetect) begin
         failSafeActive <= 1'b1;
      end else if (sleepEnter) begin
         failSafeActive <= 1'b0;
      end else if (reqAccept && !isExternal(wrSource)) begin
         failSafeActive <= 1'b0;
      end else if (switchNow && isExternal(reqSource)) begin
         failSafeActive <= 1'b0;
      end
   end

   // Control bits
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         switchHold <= 1'b0;
         secPowerHigh <= 1'b0;
      end else if (dpWrite && dpSel == 3'h2) begin
         switchHold <= hwdata[`SCS_HOLD_BIT];
         secPowerHigh <= hwdata[`SCS_SECPWR_BIT];
      end
   end

   // Sticky flags, write one to clear; a set in the same cycle wins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         oscFailFlag <= 1'b0;
         switchDoneFlag <= 1'b0;
      end else begin
         if (failDetect) begin
            oscFailFlag <= 1'b1;
         end else if (dpWrite && dpSel == 3'h4 && hwdata[`SCS_FLAG_FAIL_BIT]) begin
            oscFailFlag <= 1'b0;
         end
         if (pending && sourceReady(reqSource, readyStatus) && !newSourceReady &&
               mode == scs_pkg::MODE_RUN) begin
            switchDoneFlag <= 1'b1;
         end else if (dpWrite && dpSel == 3'h4 && hwdata[`SCS_FLAG_DONE_BIT]) begin
            switchDoneFlag <= 1'b0;
         end
      end
   end

   // Bus slave: zero wait states, read data registered in the address phase
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dpWrite <= 1'b0;
         dpSel <= 3'h7;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dpWrite <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
         dpSel <= regSelect(haddr);
         if (hsel && htrans[1] && hready && !hwrite) begin
            case (regSelect(haddr))
               3'h0: hrdata <= {24'h00_0000, 1'b0, reqSource, reqDivider};
               3'h1: hrdata <= {24'h00_0000, 1'b0, sysSource, sysDivider};
               3'h2: hrdata <= {24'h00_0000, switchHold, secPowerHigh, 1'b0, !pending,
                  newSourceReady, 3'h0};
               3'h3: hrdata <= {24'h00_0000, readyStatus};
               3'h4: hrdata <= {29'h0000_0000, failSafeActive, switchDoneFlag, oscFailFlag};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // scs_clock_switch

// *** testbench/scs_clock_switch_asserts.sv ***
`timescale 1ns/1ps
`include "scs_consts.svh"
module scs_clock_switch_asserts #(
   parameter int STARTUP_CYCLES = `SCS_STARTUP_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic externalClockInputMode,
   input wire logic sleepEnter,
   input wire logic wakeUp,
   input wire logic [2:0] sysSource,
   input wire logic [3:0] sysDivider,
   input wire logic secPowerHigh,
   input wire logic monitorActive,
   input wire logic failSafeActive,
   input wire logic oscFailFlag,
   input wire logic switchDoneFlag,
   input wire logic startupRunning
);
   logic ctlWr;
   logic [3:0] age;
   logic [15:0] runCnt;
   // Switch checks wait out the configuration capture after reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         age <= 4'h0;
         ctlWr <= 1'h0;
         runCnt <= 16'h0000;
      end else begin
         if (age != 4'hF) begin
            age <= age + 4'h1;
         end
         ctlWr <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2
            && haddr == {24'h00_0000, `SCS_OFF_CONTROL};
         runCnt <= startupRunning ? runCnt + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_okay;
      hresp == 1'h0 && hreadyout == 1'h1;
   endproperty
   property p_fail;
      $rose(failSafeActive) |-> sysSource == `SCS_SRC_HF
         && sysDivider == `SCS_DIV_FAILSAFE && oscFailFlag;
   endproperty
   property p_armed;
      $rose(failSafeActive) |-> $past(monitorActive);
   endproperty
   property p_refail;
      $rose(oscFailFlag) |-> failSafeActive;
   endproperty
   property p_sleep;
      sleepEnter |-> ##[1:2] !failSafeActive;
   endproperty
   property p_wake;
      wakeUp && !externalClockInputMode |-> ##[1:3] startupRunning;
   endproperty
   property p_secpwr;
      ctlWr |=> secPowerHigh == $past(hwdata[`SCS_SECPWR_BIT]);
   endproperty
   property p_switch;
      age == 4'hF && $changed({sysSource, sysDivider}) && !failSafeActive |-> switchDoneFlag;
   endproperty
   // A restart while counting would stretch the run and trip this
   property p_timer;
      $fell(startupRunning) && !externalClockInputMode |-> int'(runCnt) >= STARTUP_CYCLES - 1
         && int'(runCnt) <= STARTUP_CYCLES + 2;
   endproperty
   a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
   a_fail: assert property (p_fail) else $error("fail-safe entry wrong");
   a_armed: assert property (p_armed) else $error("failure seen while unarmed");
   a_refail: assert property (p_refail) else $error("fail flag without fail-safe");
   a_sleep: assert property (p_sleep) else $error("sleep kept fail-safe");
   a_wake: assert property (p_wake) else $error("wake did not start timer");
   a_secpwr: assert property (p_secpwr) else $error("power mode bit wrong");
   a_switch: assert property (p_switch) else $error("switch without ready event");
   a_timer: assert property (p_timer) else $error("start-up timer length wrong");
   c_fail: cover property ($rose(failSafeActive));
   c_ctl: cover property (ctlWr);
   c_timer: cover property ($fell(startupRunning));
endmodule // scs_clock_switch_asserts

bind scs_clock_switch scs_clock_switch_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
   .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .externalClockInputMode(externalClockInputMode), .sleepEnter(sleepEnter), .wakeUp(wakeUp),
   .sysSource(sysSource), .sysDivider(sysDivider), .secPowerHigh(secPowerHigh),
   .monitorActive(monitorActive), .failSafeActive(failSafeActive), .oscFailFlag(oscFailFlag),
   .switchDoneFlag(switchDoneFlag), .startupRunning(startupRunning));

// *** testbench/scs_osc_model.sv ***
`timescale 1ns/1ps
module scs_osc_model #(
   parameter int DLY = 5,
   parameter int LOCK = 4
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [5:0] oscOn,
   input wire logic pllOn,
   input wire logic failExt,
   output logic [5:0] oscReady,
   output logic pllEnabled,
   output logic pllLocked,
   output logic clockFail
);
   logic [5:0] prevOn;
   int cnt;
   int lockCnt;
   // Ready drops at once when a source stops, but rises only after settling
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prevOn <= 6'h00;
         cnt <= 0;
         oscReady <= 6'h00;
         lockCnt <= 0;
      end else begin
         prevOn <= oscOn;
         cnt <= (oscOn != prevOn) ? 0 : (cnt < DLY ? cnt + 1 : cnt);
         // A source counts as settled only once its enable has stood still
         oscReady <= (cnt == DLY && oscOn == prevOn) ? oscOn : (oscReady & oscOn);
         lockCnt <= (pllOn && (oscReady[5] || oscReady[4])) ?
            (lockCnt < LOCK ? lockCnt + 1 : LOCK) : 0;
      end
   end
   assign pllLocked = (lockCnt == LOCK);
   assign pllEnabled = pllOn;
   assign clockFail = failExt;
endmodule // scs_osc_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin nMismatch++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
   typedef struct {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] mask;
      logic [7:0] exp;} scs_row_t;
   localparam logic [7:0] REQ = 8'h00, CUR = 8'h04, CTL = 8'h08, RDY = 8'h0C, FLG = 8'h10,
      NONE = 8'h20;
   logic clk = 1'h0, arst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, sleepEnter = 1'h0, wakeUp = 1'h0;
   logic switchEnableConfig = 1'h1, externalClockInputMode = 1'h0, pllOn = 1'h0, failExt = 1'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, resetOscConfig = 3'h6, sysSource;
   logic [3:0] sysDivider;
   logic [5:0] oscOn = 6'h1E, oscReady;
   logic [7:0] e;
   logic hreadyout, hresp, secPowerHigh, monitorActive, failSafeActive, oscFailFlag;
   logic switchDoneFlag, startupRunning, pllEnabled, pllLocked, clockFail;
   int nMismatch = 0, compares = 0;
   logic [2:0] cfgs [3] = '{3'h5, 3'h7, 3'h6};
   // Hold and reserved-code cases depend on the rows before them
   scs_row_t rows [12] = '{'{REQ, 8'hD3, REQ, 8'hFF, 8'h53}, '{NONE, 8'hFF, CUR, 8'hFF, 8'h53},
      '{NONE, 8'hFF, NONE, 8'hFF, 8'h00}, '{REQ, 8'h31, REQ, 8'hFF, 8'h53},
      '{REQ, 8'h05, REQ, 8'hFF, 8'h53}, '{CTL, 8'hC0, CTL, 8'hD8, 8'hD0},
      '{REQ, 8'h69, CTL, 8'hD8, 8'hC8}, '{CUR, 8'h00, CUR, 8'hFF, 8'h53},
      '{CTL, 8'h00, CUR, 8'hFF, 8'h69}, '{REQ, 8'h40, CUR, 8'hFF, 8'h40},
      '{FLG, 8'h02, FLG, 8'h02, 8'h00}, '{CTL, 8'h40, CTL, 8'hD8, 8'h50}};
   scs_clock_switch #(.STARTUP_CYCLES(8)) i_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .resetOscConfig(resetOscConfig), .switchEnableConfig(switchEnableConfig),
      .externalClockInputMode(externalClockInputMode), .extOscReadyIn(oscReady[5]),
      .hfReadyIn(oscReady[4]), .mfReadyIn(oscReady[3]), .lfReadyIn(oscReady[2]),
      .secReadyIn(oscReady[1]), .convReadyIn(oscReady[0]), .pllEnabledIn(pllEnabled),
      .pllLockedIn(pllLocked), .clockFailIn(clockFail), .sleepEnter(sleepEnter), .wakeUp(wakeUp),
      .sysSource(sysSource), .sysDivider(sysDivider), .secPowerHigh(secPowerHigh),
      .monitorActive(monitorActive), .failSafeActive(failSafeActive), .oscFailFlag(oscFailFlag),
      .switchDoneFlag(switchDoneFlag), .startupRunning(startupRunning));
   scs_osc_model i_osc (.clk(clk), .arst_n(arst_n), .oscOn(oscOn), .pllOn(pllOn),
      .failExt(failExt), .oscReady(oscReady), .pllEnabled(pllEnabled), .pllLocked(pllLocked),
      .clockFail(clockFail));
   always #2 clk = ~clk;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      do @(posedge clk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
      xfer(1'h0, a, 8'h00);
      `CHK(q & {24'h00_0000, m}, {24'h00_0000, x})
   endtask
   task automatic waitCur(input logic [6:0] v);
      for (int i = 0; i < 300 && {sysSource, sysDivider} !== v; i++) @(posedge clk);
      rdChk(CUR, 8'hFF, {1'h0, v});
   endtask
   task automatic resetDut(input logic [2:0] c, input logic s, input logic x);
      resetOscConfig <= c;
      switchEnableConfig <= s;
      externalClockInputMode <= x;
      arst_n <= 1'h0;
      tick(8);
      arst_n <= 1'h1;
      tick(7);
   endtask
   task automatic summarize;
      $display("mismatches %0d compares %0d", nMismatch, compares);
      if (nMismatch == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      tick(20000);
      nMismatch++;
      summarize();
   end
   initial begin
      foreach (cfgs[i]) begin
         resetDut(cfgs[i], 1'h1, 1'h0);
         e = {1'h0, cfgs[i], cfgs[i] == 3'h6 ? 4'h2 : 4'h0};
         rdChk(REQ, 8'hFF, e);
         rdChk(CUR, 8'hFF, e);
      end
      resetDut(3'h6, 1'h0, 1'h0);
      xfer(1'h1, REQ, 8'h50);
      rdChk(REQ, 8'hFF, 8'h62);
      resetDut(3'h6, 1'h1, 1'h1);
      `CHK(startupRunning, 1'h0)
      `CHK(monitorActive, 1'h1)
      resetDut(3'h6, 1'h1, 1'h0);
      `CHK(startupRunning, 1'h1)
      foreach (rows[i]) begin
         xfer(1'h1, rows[i].wa, rows[i].wd);
         tick(12);
         rdChk(rows[i].ra, rows[i].mask,
            rows[i].exp);
      end
      oscOn <= 6'h3E;
      xfer(1'h1, REQ, 8'h70);
      tick(1);
      `CHK(startupRunning, 1'h1)
      `CHK(sysSource, 3'h4)
      waitCur(7'h70);
      failExt <= 1'h1;
      for (int i = 0; i < 60 && failSafeActive !== 1'h1; i++) @(posedge clk);
      `CHK({sysSource, sysDivider}, 7'h62)
      `CHK(oscFailFlag, 1'h1)
      xfer(1'h1, FLG, 8'h01);
      tick(1);
      `CHK(oscFailFlag, 1'h0)
      `CHK({sysSource, sysDivider}, 7'h62)
      xfer(1'h1, REQ, 8'h70);
      `CHK(failSafeActive, 1'h1)
      for (int i = 0; i < 100 && oscFailFlag !== 1'h1; i++) @(posedge clk);
      `CHK(oscFailFlag, 1'h1)
      sleepEnter <= 1'h1;
      tick(1);
      sleepEnter <= 1'h0;
      tick(2);
      `CHK(failSafeActive, 1'h0)
      failExt <= 1'h0;
      tick(20);
      `CHK({sysSource, sysDivider}, 7'h62)
      wakeUp <= 1'h1;
      tick(1);
      wakeUp <= 1'h0;
      tick(2);
      `CHK(startupRunning, 1'h1)
      waitCur(7'h70);
      xfer(1'h1, REQ, 8'h10);
      tick(20);
      rdChk(RDY, 8'h01, 8'h00);
      `CHK(sysSource, 3'h7)
      pllOn <= 1'h1;
      waitCur(7'h10);
      rdChk(RDY, 8'h01, 8'h01);
      xfer(1'h1, REQ, 8'h20);
      waitCur(7'h20);
      pllOn <= 1'h0;
      for (int i = 0; i < 6; i++) begin
         oscOn <= 6'h01 << i;
         tick(14);
         e = 8'h04 << i;
         rdChk(RDY, 8'hFF, e);
      end
      summarize();
   end
endmodule // testbench
